// file: pmsc_sideband.sv
// Sideband control core: pins, two-wire slave, management bytes
`timescale 1ns/1ns
// How it works
// RULE1: Selected module answers and acts on two-wire management commands.
// RULE2: Deselected module never acknowledges nor drives the data line.
// RULE3: Undriven select input reads as high, leaving the module deselected.
// RULE4: Undriven reset input reads as high, module out of reset.
// RULE5: Reset low beyond minimum pulse restores all settings to defaults.
// RULE6: Init interval timing starts at the rising edge ending reset.
// RULE7: Attention releases after init pending read as 0 and flags read.
// RULE8: Presence output is permanently driven low.
// RULE9: Undriven low-power input reads as high, requesting low power.
// RULE10: Power mode combines pin with override and set bits, byte 93.
// RULE11: Override set selects power-set bit, else pin level decides.
// RULE12: During init interval attention stays released, init pending set.
module pmsc_sideband #(
    parameter logic [31:0] RESET_PULSE_NS = pmsc_pkg::RST_PULSE_NS_DEF,
    parameter logic [31:0] INIT_TIME_NS   = pmsc_pkg::INIT_TIME_NS_DEF
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // Module select pin and its driven indication
    input  wire logic module_select_n_i,
    input  wire logic module_select_drv_i,
    // Module reset pin and its driven indication
    input  wire logic module_reset_n_i,
    input  wire logic module_reset_drv_i,
    // Low-power pin and its driven indication
    input  wire logic low_power_pin_i,
    input  wire logic low_power_drv_i,
    // Two-wire management bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Open-drain attention and presence pins
    output logic      attention_n_o,
    output logic      attention_oe_o,
    output logic      module_present_n_o,
    output logic      module_present_oe_o,
    // Status
    output logic      low_power_mode_o,
    output logic      init_pending_o,
    output logic      module_in_reset_o
);
    import pmsc_pkg::*;
    // ----------
    // Timing counts
    // ----------
    localparam logic [31:0] PULSE_RAW = (RESET_PULSE_NS + CLK_PERIOD_NS
                                         - 32'd1) / CLK_PERIOD_NS;
    localparam logic [31:0] INIT_RAW  = (INIT_TIME_NS + CLK_PERIOD_NS
                                         - 32'd1) / CLK_PERIOD_NS;
    localparam logic [31:0] PULSE_CYC = (PULSE_RAW == 32'h0) ? 32'd1
                                        : PULSE_RAW;
    localparam logic [31:0] INIT_CYC  = (INIT_RAW == 32'h0) ? 32'd1
                                        : INIT_RAW;
    typedef enum logic [3:0] {
        TW_IDLE, TW_ADDR, TW_AACK, TW_REG, TW_PACK,
        TW_WDATA, TW_WACK, TW_RDATA, TW_MACK
    } pmsc_tw_e;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction
    // ----------
    // Pin synchronisers
    // ----------
    logic [PIN_N-1:0] pins_raw;
    logic [PIN_N-1:0] meta_ff;
    logic [PIN_N-1:0] pin_ff;
    assign pins_raw = {sda_i, scl_i, low_power_drv_i, low_power_pin_i,
                       module_reset_drv_i, module_reset_n_i,
                       module_select_drv_i, module_select_n_i};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_sync
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_ff[gi] <= 1'b1;
                    pin_ff[gi]  <= 1'b1;
                end else begin
                    meta_ff[gi] <= pins_raw[gi];
                    pin_ff[gi]  <= meta_ff[gi];
                end
            end
        end
    endgenerate
    // Internal bias: an undriven pin reads as high
    wire sel_n_eff = !pin_ff[PIN_SEL_DRV] || pin_ff[PIN_SEL]; // RULE3
    wire rst_n_eff = !pin_ff[PIN_RST_DRV] || pin_ff[PIN_RST]; // RULE4
    wire lp_eff    = !pin_ff[PIN_LP_DRV] || pin_ff[PIN_LP]; // RULE9
    wire scl       = pin_ff[PIN_SCL];
    wire sda       = pin_ff[PIN_SDA];
    // ----------
    // Reset timer
    // ----------
    pmsc_rst_if rst ();
    assign rst.pin_low = !rst_n_eff;
    pmsc_reset_timer #(
        .PULSE_CYC (PULSE_CYC),
        .INIT_CYC  (INIT_CYC)
    ) u_timer (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .rst     (rst)
    );
    // ----------
    // Two-wire slave
    // ----------
    pmsc_tw_e   st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] rx_ff, nxt_rx;
    logic [7:0] tx_ff, nxt_tx;
    logic [7:0] ptr_ff, nxt_ptr;
    logic       rw_ff, nxt_rw;
    logic       oe_ff, nxt_oe;
    logic       mack_ff, nxt_mack;
    logic       wr_stb, rd_stb;
    logic       scl_p_ff, sda_p_ff;
    logic [7:0] rdata;
    wire tw_en    = !sel_n_eff && !rst.held; // RULE1 RULE2
    wire scl_rise = scl && !scl_p_ff;
    wire scl_fall = !scl && scl_p_ff;
    wire start    = scl && scl_p_ff && sda_p_ff && !sda;
    wire stop     = scl && scl_p_ff && !sda_p_ff && sda;
    wire shifting = (st_ff == TW_ADDR) || (st_ff == TW_REG)
                    || (st_ff == TW_WDATA);
    wire byte_end = scl_fall && (cnt_ff == 4'd8);
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_rx   = rx_ff;
        nxt_tx   = tx_ff;
        nxt_ptr  = ptr_ff;
        nxt_rw   = rw_ff;
        nxt_oe   = oe_ff;
        nxt_mack = mack_ff;
        wr_stb   = 1'b0;
        rd_stb   = 1'b0;
        if (!tw_en) begin
            nxt_st = TW_IDLE; // RULE2
            nxt_oe = 1'b0;
        end else if (start) begin
            nxt_st  = TW_ADDR;
            nxt_cnt = 4'd0;
            nxt_oe  = 1'b0;
        end else if (stop) begin
            nxt_st = TW_IDLE;
            nxt_oe = 1'b0;
        end else if (shifting && scl_rise) begin
            nxt_rx  = {rx_ff[6:0], sda};
            nxt_cnt = cnt_ff + 4'd1;
        end else if (shifting && byte_end) begin
            nxt_cnt = 4'd0;
            nxt_oe  = 1'b1;
            case (st_ff)
                TW_ADDR: begin
                    nxt_rw = rx_ff[0];
                    if (rx_ff[7:1] == DEV_ADDR) begin
                        nxt_st = TW_AACK;
                    end else begin
                        nxt_st = TW_IDLE;
                        nxt_oe = 1'b0;
                    end
                end
                TW_REG: begin
                    nxt_ptr = rx_ff;
                    nxt_st  = TW_PACK;
                end
                default: begin
                    wr_stb = 1'b1; // RULE1
                    nxt_st = TW_WACK;
                end
            endcase
        end else begin
            case (st_ff)
                TW_AACK, TW_MACK: begin
                    if (scl_rise && st_ff == TW_MACK)
                        nxt_mack = !sda;
                    if (scl_fall) begin
                        nxt_oe = 1'b0;
                        if (st_ff == TW_MACK ? mack_ff : rw_ff) begin
                            rd_stb  = 1'b1;
                            nxt_tx  = {rdata[6:0], 1'b0};
                            nxt_oe  = !rdata[7];
                            nxt_ptr = ptr_ff + 8'd1;
                            nxt_cnt = 4'd1;
                            nxt_st  = TW_RDATA;
                        end else if (st_ff == TW_MACK) begin
                            nxt_st = TW_IDLE;
                        end else begin
                            nxt_cnt = 4'd0;
                            nxt_st  = TW_REG;
                        end
                    end
                end
                TW_PACK, TW_WACK: begin
                    if (scl_fall) begin
                        nxt_oe  = 1'b0;
                        nxt_cnt = 4'd0;
                        nxt_st  = TW_WDATA;
                        if (st_ff == TW_WACK)
                            nxt_ptr = ptr_ff + 8'd1;
                    end
                end
                TW_RDATA: begin
                    if (byte_end) begin
                        nxt_oe = 1'b0;
                        nxt_st = TW_MACK;
                    end else if (scl_fall) begin
                        nxt_oe  = !tx_ff[7];
                        nxt_tx  = {tx_ff[6:0], 1'b0};
                        nxt_cnt = cnt_ff + 4'd1;
                    end
                end
                default: nxt_st = st_ff;
            endcase
        end
    end
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff    <= TW_IDLE;
            cnt_ff   <= 4'h0;
            rx_ff    <= 8'h00;
            tx_ff    <= 8'h00;
            ptr_ff   <= 8'h00;
            rw_ff    <= 1'b0;
            oe_ff    <= 1'b0;
            mack_ff  <= 1'b0;
            scl_p_ff <= 1'b1;
            sda_p_ff <= 1'b1;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            rx_ff    <= nxt_rx;
            tx_ff    <= nxt_tx;
            ptr_ff   <= nxt_ptr;
            rw_ff    <= nxt_rw;
            oe_ff    <= nxt_oe;
            mack_ff  <= nxt_mack;
            scl_p_ff <= scl;
            sda_p_ff <= sda;
        end
    end
    // ----------
    // Management bytes
    // ----------
    logic [1:0] pwr_ctrl_ff;
    logic       init_pend_ff;
    logic       rst_done_ff;
    logic       attn_ff;
    logic       seen_ready_ff;
    logic       seen_flags_ff;
    logic       lp_mode_ff;
    wire rd_status = rd_stb && hit(ptr_ff, STATUS_BYTE);
    wire rd_flags  = rd_stb && hit(ptr_ff, FLAG_BYTE);
    wire wr_pwr    = wr_stb && hit(ptr_ff, PWR_CTRL_BYTE);
    wire ready_rd  = rd_status && !init_pend_ff; // RULE7
    wire pwr_ovr   = pwr_ctrl_ff[PWR_OVR_BIT];
    wire pwr_set   = pwr_ctrl_ff[PWR_SET_BIT];
    wire lp_sel    = pwr_ovr ? pwr_set : lp_eff; // RULE10 RULE11
    assign rdata = hit(ptr_ff, STATUS_BYTE)   ? {7'h00, init_pend_ff}
                 : hit(ptr_ff, FLAG_BYTE)     ? {7'h00, rst_done_ff}
                 : hit(ptr_ff, PWR_CTRL_BYTE) ? {6'h00, pwr_ctrl_ff}
                 : 8'h00;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            pwr_ctrl_ff <= PWR_CTRL_DEF;
        else if (rst.held)
            pwr_ctrl_ff <= PWR_CTRL_DEF; // RULE5
        else if (wr_pwr)
            pwr_ctrl_ff <= rx_ff[1:0];
    end
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_pend_ff <= 1'b1;
            rst_done_ff  <= 1'b0;
        end else if (rst.held || rst.init_run) begin
            init_pend_ff <= 1'b1; // RULE12
            rst_done_ff  <= 1'b0; // RULE5
        end else if (rst.init_done) begin
            init_pend_ff <= 1'b0;
            rst_done_ff  <= 1'b1;
        end else if (rd_flags) begin
            rst_done_ff  <= 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            attn_ff       <= 1'b0;
            seen_ready_ff <= 1'b0;
            seen_flags_ff <= 1'b0;
        end else if (rst.held || rst.init_run) begin
            attn_ff       <= 1'b0; // RULE12
            seen_ready_ff <= 1'b0;
            seen_flags_ff <= 1'b0;
        end else if (rst.init_done) begin
            attn_ff       <= 1'b1;
            seen_ready_ff <= 1'b0;
            seen_flags_ff <= 1'b0;
        end else begin
            seen_ready_ff <= seen_ready_ff || ready_rd;
            seen_flags_ff <= seen_flags_ff || rd_flags;
            if ((seen_ready_ff || ready_rd) && (seen_flags_ff || rd_flags))
                attn_ff <= 1'b0; // RULE7
        end
    end
    // ----------
    // Output flops
    // ----------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lp_mode_ff          <= 1'b1;
            sda_o               <= 1'b0;
            attention_n_o       <= 1'b0;
            attention_oe_o      <= 1'b0;
            module_present_n_o  <= 1'b0;
            module_present_oe_o <= 1'b1;
            init_pending_o      <= 1'b1;
            module_in_reset_o   <= 1'b0;
        end else begin
            lp_mode_ff          <= lp_sel; // RULE10
            sda_o               <= 1'b0;
            attention_n_o       <= 1'b0;
            attention_oe_o      <= attn_ff; // RULE7
            module_present_n_o  <= 1'b0; // RULE8
            module_present_oe_o <= 1'b1; // RULE8
            init_pending_o      <= init_pend_ff;
            module_in_reset_o   <= rst.held;
        end
    end
    assign sda_oe_o         = oe_ff;
    assign low_power_mode_o = lp_mode_ff;
endmodule

// file: pmsc_pkg.sv
// Shared constants for the pluggable module sideband control block
package pmsc_pkg;
    // ----------
    // Clock and timing
    // ----------
    localparam logic [31:0] CLK_PERIOD_NS    = 32'd20;
    localparam logic [31:0] RST_PULSE_NS_DEF = 32'd10000;
    localparam logic [31:0] INIT_TIME_NS_DEF = 32'd2000000000;

    // ----------
    // Management space
    // ----------
    localparam logic [6:0] DEV_ADDR      = 7'h50;
    localparam logic [7:0] STATUS_BYTE   = 8'h02;
    localparam logic [7:0] FLAG_BYTE     = 8'h03;
    localparam logic [7:0] PWR_CTRL_BYTE = 8'h5D;
    localparam int         INIT_PEND_BIT = 0;
    localparam int         RST_DONE_BIT  = 0;
    localparam int         PWR_OVR_BIT   = 0;
    localparam int         PWR_SET_BIT   = 1;
    localparam logic [1:0] PWR_CTRL_DEF  = 2'h0;

    // ----------
    // Pin sampling vector positions
    // ----------
    localparam int PIN_N       = 8;
    localparam int PIN_SEL     = 0;
    localparam int PIN_SEL_DRV = 1;
    localparam int PIN_RST     = 2;
    localparam int PIN_RST_DRV = 3;
    localparam int PIN_LP      = 4;
    localparam int PIN_LP_DRV  = 5;
    localparam int PIN_SCL     = 6;
    localparam int PIN_SDA     = 7;
endpackage

// file: pmsc_rst_if.sv
// Carrier between the sideband core and its reset timer
`timescale 1ns/1ns
interface pmsc_rst_if;
    logic pin_low;
    logic held;
    logic init_run;
    logic init_done;

    modport core  (output pin_low, input held, input init_run,
                   input init_done);
    modport timer (input pin_low, output held, output init_run,
                   output init_done);
endinterface

// file: pmsc_reset_timer.sv
// Reset pulse qualifier and init interval timer
`timescale 1ns/1ns
module pmsc_reset_timer #(
    parameter logic [31:0] PULSE_CYC = 32'd500,
    parameter logic [31:0] INIT_CYC  = 32'd100000000
) (
    // Clock and reset
    input  wire logic  clock_i,
    input  wire logic  nrst_i,
    // Core side
    pmsc_rst_if.timer  rst
);
    import pmsc_pkg::*;

    typedef enum logic [1:0] {TM_READY, TM_HELD, TM_INIT} pmsc_tm_e;

    pmsc_tm_e    st_ff;
    pmsc_tm_e    nxt_st;
    logic [31:0] low_cnt_ff;
    logic [31:0] init_cnt_ff;
    logic        done_ff;
    wire         qualified = rst.pin_low && (low_cnt_ff >= PULSE_CYC);
    wire         init_end  = (st_ff == TM_INIT)
                             && (init_cnt_ff >= INIT_CYC - 32'd1);

    // ----------
    // Low level length and init interval counters
    // ----------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_cnt_ff  <= 32'h0;
            init_cnt_ff <= 32'h0;
        end else begin
            if (!rst.pin_low)
                low_cnt_ff <= 32'h0;
            else if (!qualified)
                low_cnt_ff <= low_cnt_ff + 32'd1;
            if (st_ff != TM_INIT)
                init_cnt_ff <= 32'h0; // RULE6
            else if (!init_end)
                init_cnt_ff <= init_cnt_ff + 32'd1;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            TM_READY: if (qualified) nxt_st = TM_HELD; // RULE5
            TM_HELD:  if (!rst.pin_low) nxt_st = TM_INIT; // RULE6
            TM_INIT: begin
                if (qualified)
                    nxt_st = TM_HELD;
                else if (init_end)
                    nxt_st = TM_READY;
            end
            default:  nxt_st = TM_READY;
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff   <= TM_INIT;
            done_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            done_ff <= init_end && !qualified;
        end
    end

    assign rst.held      = (st_ff == TM_HELD);
    assign rst.init_run  = (st_ff == TM_INIT);
    assign rst.init_done = done_ff;
endmodule

// file: pmsc_sideband_chk.sv
// Concurrent checks on the sideband core ports
`timescale 1ns/1ns
module pmsc_sideband_chk #(
    parameter logic [31:0] RESET_PULSE_NS = 32'h64,
    parameter logic [31:0] INIT_TIME_NS   = 32'h3E8
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // Pins
    input  wire logic module_select_n_i,
    input  wire logic module_select_drv_i,
    input  wire logic module_reset_n_i,
    input  wire logic module_reset_drv_i,
    input  wire logic low_power_pin_i,
    input  wire logic low_power_drv_i,
    // Outputs
    input  wire logic sda_oe_o,
    input  wire logic attention_oe_o,
    input  wire logic module_present_n_o,
    input  wire logic module_present_oe_o,
    input  wire logic low_power_mode_o,
    input  wire logic init_pending_o,
    input  wire logic module_in_reset_o
);
    import pmsc_pkg::*;
    // ----------
    // Helper counters
    // ----------
    localparam int PULSE_CYC = int'(RESET_PULSE_NS / CLK_PERIOD_NS);
    localparam int INIT_CYC  = int'(INIT_TIME_NS / CLK_PERIOD_NS);
    logic [15:0] low_cnt_ff, init_cnt_ff, nxt_low_cnt, nxt_init_cnt;
    logic        rst_low, lp_eff;
    assign rst_low      = module_reset_drv_i & ~module_reset_n_i;
    assign lp_eff       = low_power_pin_i | ~low_power_drv_i;
    assign nxt_low_cnt  = rst_low ? low_cnt_ff + 16'h0001 : 16'h0000;
    assign nxt_init_cnt = module_in_reset_o ? 16'h0000 :
                          init_cnt_ff + {15'h0000, ~&init_cnt_ff};
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_cnt_ff  <= 16'h0000;
            init_cnt_ff <= 16'h0000;
        end else begin
            low_cnt_ff  <= nxt_low_cnt;
            init_cnt_ff <= nxt_init_cnt;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    property p_present;
        module_present_oe_o && !module_present_n_o;
    endproperty
    a_present: assert property (p_present) else $error("presence");
    property p_desel;
        (module_select_drv_i && module_select_n_i)[*5] |-> !sda_oe_o;
    endproperty
    a_desel: assert property (p_desel) else $error("deselected");
    property p_sel_undrv;
        (!module_select_drv_i)[*5] |-> !sda_oe_o;
    endproperty
    a_sel_undrv: assert property (p_sel_undrv) else $error("sel float");
    property p_rst_undrv;
        (!module_reset_drv_i)[*5] |-> !module_in_reset_o;
    endproperty
    a_rst_undrv: assert property (p_rst_undrv) else $error("rst float");
    property p_rst_min;
        $rose(module_in_reset_o) |-> low_cnt_ff >= PULSE_CYC;
    endproperty
    a_rst_min: assert property (p_rst_min) else $error("short pulse");
    property p_held;
        module_in_reset_o[*2] |->
            init_pending_o && !attention_oe_o && !sda_oe_o;
    endproperty
    a_held: assert property (p_held) else $error("held state");
    property p_init_time;
        $fell(init_pending_o) |->
            init_cnt_ff >= INIT_CYC - 1 && init_cnt_ff <= INIT_CYC + 5;
    endproperty
    a_init_time: assert property (p_init_time) else $error("init time");
    property p_attn;
        $rose(attention_oe_o) |-> ##[0:1] !init_pending_o;
    endproperty
    a_attn: assert property (p_attn) else $error("attention");
    property p_power;
        (module_in_reset_o && $stable(lp_eff))[*4] |->
            low_power_mode_o == lp_eff;
    endproperty
    a_power: assert property (p_power) else $error("power mode");
endmodule
bind pmsc_sideband pmsc_sideband_chk #(
    .RESET_PULSE_NS(RESET_PULSE_NS),
    .INIT_TIME_NS  (INIT_TIME_NS)
) u_chk (
    .clock_i            (clock_i),
    .nrst_i             (nrst_i),
    .module_select_n_i  (module_select_n_i),
    .module_select_drv_i(module_select_drv_i),
    .module_reset_n_i   (module_reset_n_i),
    .module_reset_drv_i (module_reset_drv_i),
    .low_power_pin_i    (low_power_pin_i),
    .low_power_drv_i    (low_power_drv_i),
    .sda_oe_o           (sda_oe_o),
    .attention_oe_o     (attention_oe_o),
    .module_present_n_o (module_present_n_o),
    .module_present_oe_o(module_present_oe_o),
    .low_power_mode_o   (low_power_mode_o),
    .init_pending_o     (init_pending_o),
    .module_in_reset_o  (module_in_reset_o)
);

// file: pmsc_host_model.sv
// Two-wire host controller model for the management bus
`timescale 1ns/1ns
module pmsc_host_model (
    // Clock and bus
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    import pmsc_pkg::*;
    // ----------
    // Bus phases, eight clocks each
    // ----------
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic half();
        repeat (8) @(posedge clock_i);
    endtask
    task automatic start();
        sda_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_o <= 1'b1;
        half();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
        half();
    endtask
    // Ninth bit released: ack on writes, no-ack ends a read
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                           output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                      output logic ack);
        logic [7:0] rx;
        logic       a0, a1, a2;
        start();
        byte_io({DEV_ADDR, 1'b0}, rx, a0);
        byte_io(ptr, rx, a1);
        byte_io(d, rx, a2);
        stop();
        ack = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d,
                      output logic ack);
        logic [7:0] rx;
        logic       a0, a1, a2, a3;
        start();
        byte_io({DEV_ADDR, 1'b0}, rx, a0);
        byte_io(ptr, rx, a1);
        start();
        byte_io({DEV_ADDR, 1'b1}, rx, a2);
        byte_io(8'hFF, d, a3);
        stop();
        ack = a0 & a1 & a2;
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the sideband core
`timescale 1ns/1ns
module tb_top;
    import pmsc_pkg::*;
    // ----------
    // Bench
    // ----------
    logic       clock_i, nrst_i, sel_n, sel_drv, rst_n, rst_drv, lp, lp_drv;
    logic       scl, host_sda, sda_o, sda_oe, att_o, att_oe, prs_n, prs_oe;
    logic       lp_mode, init_pend, in_rst, ack;
    logic [7:0] d;
    wire        sda_w = host_sda & ~(sda_oe & ~sda_o);
    int         err_count, n_tests;
    pmsc_sideband #(.RESET_PULSE_NS(32'h64), .INIT_TIME_NS(32'h3E8)) uut (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .module_select_n_i(sel_n), .module_select_drv_i(sel_drv),
        .module_reset_n_i(rst_n), .module_reset_drv_i(rst_drv),
        .low_power_pin_i(lp), .low_power_drv_i(lp_drv),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .attention_n_o(att_o), .attention_oe_o(att_oe),
        .module_present_n_o(prs_n), .module_present_oe_o(prs_oe),
        .low_power_mode_o(lp_mode), .init_pending_o(init_pend),
        .module_in_reset_o(in_rst));
    pmsc_host_model host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
                          .sda_o(host_sda));
    initial clock_i = 1'b0;
    always #10 clock_i = ~clock_i;
    function automatic logic [7:0] b8(input logic v);
        return {7'h00, v};
    endfunction
    task automatic chk(input string nm, input logic [7:0] got,
                       input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_por();
        chk("present_n", b8(prs_n), 8'h00);
        chk("present_oe", b8(prs_oe), 8'h01);
        chk("init_pend", b8(init_pend), 8'h01);
        chk("attn_early", b8(att_oe), 8'h00);
        chk("lp_undrv", b8(lp_mode), 8'h01);
        chk("sda_lvl", b8(sda_o), 8'h00);
        cyc(70);
        chk("init_done", b8(init_pend), 8'h00);
        chk("attn_set", b8(att_oe), 8'h01);
        chk("attn_lvl", b8(att_o), 8'h00);
    endtask
    task automatic t_attn();
        host.rd(STATUS_BYTE, d, ack);
        chk("rd_ack", b8(ack), 8'h01);
        chk("not_ready", d & 8'h01, 8'h00);
        cyc(4);
        chk("attn_hold", b8(att_oe), 8'h01);
        host.rd(FLAG_BYTE, d, ack);
        chk("flag", d & 8'h01, 8'h01);
        cyc(4);
        chk("attn_rel", b8(att_oe), 8'h00);
        host.rd(FLAG_BYTE, d, ack);
        chk("flag_clr", d & 8'h01, 8'h00);
    endtask
    task automatic t_power();
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            lp_drv <= 1'b1;
            lp <= v[2];
            host.wr(PWR_CTRL_BYTE, {6'h00, v[1:0]}, ack);
            host.rd(PWR_CTRL_BYTE, d, ack);
            chk("pwr_bits", d & 8'h03, {6'h00, v[1:0]});
            chk("pwr_mode", b8(lp_mode), b8(v[0] ? v[1] : v[2]));
        end
        lp_drv <= 1'b0;
        lp <= 1'b0;
        host.wr(PWR_CTRL_BYTE, 8'h00, ack);
        chk("lp_float", b8(lp_mode), 8'h01);
    endtask
    task automatic t_select();
        sel_n <= 1'b1;
        cyc(5);
        host.wr(PWR_CTRL_BYTE, 8'h03, ack);
        chk("desel_ack", b8(ack), 8'h00);
        sel_drv <= 1'b0;
        sel_n <= 1'b0;
        cyc(5);
        host.wr(PWR_CTRL_BYTE, 8'h03, ack);
        chk("undrv_ack", b8(ack), 8'h00);
        sel_drv <= 1'b1;
        cyc(5);
        host.rd(PWR_CTRL_BYTE, d, ack);
        chk("sel_ack", b8(ack), 8'h01);
        chk("sel_kept", d & 8'h03, 8'h00);
    endtask
    task automatic t_rst_pin();
        host.wr(PWR_CTRL_BYTE, 8'h01, ack);
        cyc(4);
        chk("ovr_mode", b8(lp_mode), 8'h00);
        rst_drv <= 1'b0;
        rst_n <= 1'b0;
        cyc(20);
        chk("rst_undrv", b8(in_rst), 8'h00);
        rst_drv <= 1'b1;
        cyc(3);
        rst_n <= 1'b1;
        cyc(10);
        chk("short_pulse", b8(in_rst), 8'h00);
        chk("short_keep", b8(lp_mode), 8'h00);
        rst_n <= 1'b0;
        cyc(12);
        chk("held", b8(in_rst), 8'h01);
        host.wr(PWR_CTRL_BYTE, 8'h03, ack);
        chk("held_ack", b8(ack), 8'h00);
        rst_n <= 1'b1;
        cyc(10);
        chk("released", b8(in_rst), 8'h00);
        chk("dflt_mode", b8(lp_mode), 8'h01);
        chk("init_run", b8(init_pend), 8'h01);
        chk("attn_off", b8(att_oe), 8'h00);
        cyc(60);
        chk("init_end", b8(init_pend), 8'h00);
        host.rd(PWR_CTRL_BYTE, d, ack);
        chk("dflt_bits", d & 8'h03, 8'h00);
    endtask
    initial begin
        nrst_i = 1'b0;
        sel_n = 1'b0;
        sel_drv = 1'b1;
        rst_n = 1'b1;
        rst_drv = 1'b1;
        lp = 1'b0;
        lp_drv = 1'b0;
        cyc(16);
        nrst_i <= 1'b1;
        cyc(4);
        t_por();
        t_attn();
        t_power();
        t_select();
        t_rst_pin();
        end_of_test();
    end
    // Watchdog, about four and a half times the expected run
    initial begin
        cyc(100000);
        err_count++;
        end_of_test();
    end
endmodule
